// ### shared/efc_consts.vh
// Constants of the embedded flash controller: register offsets, field
// positions, reset values, geometry and timing counts.
// Assumes a 100 MHz core clock and a 32-bit APB register port.
`ifndef EFC_CONSTS_VH
`define EFC_CONSTS_VH

// Register byte offsets
`define EFC_REG_CTRL 12'h000
`define EFC_REG_STAT 12'h004
`define EFC_REG_CMD 12'h008
`define EFC_REG_WST 12'h010
`define EFC_REG_LIDX 12'h018
`define EFC_REG_DATA0 12'h020
`define EFC_REG_SECLO 12'h030
`define EFC_REG_SECHI 12'h034

// Control register fields
`define EFC_CTRL_ASYNC 4
`define EFC_CTRL_LATCH 5
`define EFC_CTRL_INDEX 6
`define EFC_CTRL_BYPASS 13
`define EFC_CTRL_LINE2 16
`define EFC_CTRL_SPEC 17
`define EFC_CTRL_RST 32'h0000_0000

// Status register fields
`define EFC_ST_INIT 0
`define EFC_ST_BUSY 1
`define EFC_ST_BURN 2
`define EFC_ST_ERASE 3
`define EFC_ST_REFUSED 4
`define EFC_ST_JPROT 5

// Command register fields
`define EFC_CMD_BURN 0
`define EFC_CMD_ERASE 1
`define EFC_CMD_PAGE_LSB 16

// Wait-state register reset value
`define EFC_WST_RST 8'h04

// Index sector layout: protection bit and per-sector security bits
`define EFC_IDX_JPROT 0
`define EFC_IDX_SEC_LSB 32

// Array geometry
`define EFC_SECTORS 48
`define EFC_PAGES_PER_SECTOR 16
`define EFC_WORDS_PER_PAGE 32

// Initialization time and the cycle count derived from it
`define EFC_T_INIT_NS 10000
`define EFC_CLK_MHZ 100
`define EFC_INIT_CYC ((`EFC_T_INIT_NS * `EFC_CLK_MHZ) / 1000)

`endif

// ### rtl/efc_sync.v
// Two-stage synchroniser for a group of pin-level inputs.
// Assumes the inputs are quasi-static levels from another clock domain.
`timescale 1ns/1ps

module efc_sync #(
    parameter WIDTH = 1
) (
    input wire i_core_clk, // Core clock
    input wire i_rst_n, // Synchronous reset, active low
    input wire [WIDTH-1:0] i_async, // Unsynchronised levels
    output reg [WIDTH-1:0] o_sync // Synchronised levels
);

// First stage, read only by the second stage
reg [WIDTH-1:0] meta;

////////////////////////////////////////////////////////////////////////////////
// Two flip-flops in series
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        meta <= {WIDTH{1'b0}};
        o_sync <= {WIDTH{1'b0}};
    end else begin
        meta <= i_async;
        o_sync <= meta;
    end
end

endmodule // efc_sync

// ### rtl/efc_flash_ctrl.v
// Embedded flash controller: initialization, buffered reads of the 128-bit
// flash word array, page programming and sector erase, APB registers.
// Assumes a flash macro on the core clock and a JTAG agent on pins.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "efc_consts.vh"

module efc_flash_ctrl #(
    parameter INIT_CYC = `EFC_INIT_CYC, // Initialization length in cycles
    parameter SECTORS = `EFC_SECTORS // Number of sectors
) (
    input wire i_core_clk, // Core clock, 100 MHz
    input wire i_rst_n, // Synchronous reset, active low
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB direction
    input wire [11:0] i_paddr, // APB byte address
    input wire [31:0] i_pwdata, // APB write data
    output reg [31:0] o_prdata, // APB read data
    output reg o_pready, // APB ready
    output reg o_pslverr, // APB error on unmapped address
    input wire i_rd_req, // Read request pulse
    input wire [18:0] i_rd_addr, // Read byte address
    output reg [31:0] o_rd_data, // Read data
    output reg o_rd_ready, // Read answer pulse
    output reg o_fl_rd, // Flash read request level
    output reg [14:0] o_fl_addr, // Flash word address
    output reg o_fl_index, // Flash read targets index sector
    output reg o_fl_latch, // Flash read targets data latches
    output reg o_fl_abort, // Abort running flash read
    input wire i_fl_rvalid, // Flash read data valid pulse
    input wire [127:0] i_fl_rdata, // Flash read word
    output reg o_fl_load, // Load one word into page latches
    output reg [4:0] o_fl_load_idx, // Latch word index in page
    output reg [127:0] o_fl_wdata, // Latch word data
    output reg o_fl_burn, // Start page burn pulse
    output reg o_fl_erase, // Start sector erase pulse
    output reg [9:0] o_fl_page, // Page number for burn or erase
    input wire i_fl_op_done, // Burn or erase finished pulse
    input wire i_jtag_req, // JTAG program request pin
    input wire i_jtag_erase, // JTAG asks erase, else burn
    input wire [9:0] i_jtag_page, // JTAG page number
    output reg o_jtag_refused, // JTAG request refused
    output reg o_dbg_disable, // Debug facilities disabled
    output reg o_burn_evt, // Burn finished event pulse
    output reg o_erase_evt // Erase finished event pulse
);

// One-hot states
localparam [5:0] S_INIT = 6'h01;
localparam [5:0] S_IDXRD = 6'h02;
localparam [5:0] S_IDLE = 6'h04;
localparam [5:0] S_FLRD = 6'h08;
localparam [5:0] S_WST = 6'h10;
localparam [5:0] S_PROG = 6'h20;

reg [5:0] state; // Sequencer state
reg [15:0] init_cnt; // Initialization cycle counter
reg [31:0] ctrl; // Control register
reg [7:0] wait_state_count; // Wait-state count
reg jprot; // JTAG protection from index sector
reg [SECTORS-1:0] secure; // Per-sector security
reg init_done; // Initialization finished
reg st_burn, st_erase, st_refused; // Sticky status flags
reg [95:0] wbuf; // Low three latch data words
reg [4:0] lidx; // Next latch word index
reg prog_pend, prog_erase; // Queued program command
reg [9:0] prog_page; // Queued page
reg op_erase; // Running operation is erase
reg req_pend; // Read request waiting
reg [18:0] req_addr; // Captured read address
reg [127:0] p_data, s_data; // Primary and secondary lines
reg [14:0] p_tag, s_tag; // Line word addresses
reg p_valid, s_valid; // Line valid bits
reg spec_busy; // Speculative read in flight
reg spec_allow; // One speculative read allowed
reg [127:0] hold; // Word held during wait states
reg [7:0] wcnt; // Wait-state counter
reg jtag_seen; // Previous synchronised request

wire [11:0] jtag_sync; // Synchronised JTAG pins
wire jreq = jtag_sync[11];
wire apb_acc = i_psel & i_penable & o_pready;
wire apb_wr = apb_acc & i_pwrite;
wire [14:0] req_word = req_addr[18:4];
wire async_md = ctrl[`EFC_CTRL_ASYNC];
wire latch_md = ctrl[`EFC_CTRL_LATCH];
wire index_md = ctrl[`EFC_CTRL_INDEX];
wire bypass_md = ctrl[`EFC_CTRL_BYPASS] | latch_md | index_md;
wire dual_md = async_md & ~bypass_md & ctrl[`EFC_CTRL_LINE2];
wire p_hit = p_valid & (p_tag == req_word);
wire s_hit = s_valid & (s_tag == req_word);
wire sec_hit = prog_page[9:4] < SECTORS;
wire [5:0] prog_sector = prog_page[9:4];
wire cfg_acc = apb_acc & ((i_paddr == `EFC_REG_CTRL) | (i_paddr == `EFC_REG_WST));
wire map_ok = (i_paddr == `EFC_REG_CTRL) | (i_paddr == `EFC_REG_STAT) | (i_paddr == `EFC_REG_CMD) |
    (i_paddr == `EFC_REG_WST) | (i_paddr == `EFC_REG_LIDX) | (i_paddr[11:4] == 8'h02) |
    (i_paddr == `EFC_REG_SECLO) | (i_paddr == `EFC_REG_SECHI);

////////////////////////////////////////////////////////////////////////////////
// JTAG pins through two flip-flops
efc_sync #(
    .WIDTH(12)
) u_jtag_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_jtag_req, i_jtag_erase, i_jtag_page}),
    .o_sync(jtag_sync)
);

// word select from a flash word
function [31:0] pick;
    input [127:0] w;
    input [1:0] sel;
    begin
        pick = w[sel*32 +: 32];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// APB slave: no wait cycle, ready and answer registered in the setup phase
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata <= 32'h0000_0000;
    end else begin
        o_pready <= i_psel & ~i_penable;
        o_pslverr <= i_psel & ~i_penable & ~map_ok;
        o_prdata <= 32'h0000_0000;
        if (i_psel & ~i_penable & ~i_pwrite) begin
            case (i_paddr)
                `EFC_REG_CTRL: o_prdata <= ctrl;
                `EFC_REG_STAT: o_prdata <= {26'h000_0000, jprot, st_refused, st_erase, st_burn,
                    (state == S_PROG) | prog_pend, init_done};
                `EFC_REG_WST: o_prdata <= {24'h00_0000, wait_state_count};
                `EFC_REG_LIDX: o_prdata <= {27'h000_0000, lidx};
                `EFC_REG_SECLO: o_prdata <= secure[31:0];
                `EFC_REG_SECHI: o_prdata <= {16'h0000, secure[SECTORS-1:32]};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration, latch loading and status flags
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        ctrl <= `EFC_CTRL_RST;
        wait_state_count <= `EFC_WST_RST;
        wbuf <= 96'h0;
        lidx <= 5'h00;
        o_fl_load <= 1'b0;
        o_fl_load_idx <= 5'h00;
        o_fl_wdata <= 128'h0;
        st_burn <= 1'b0;
        st_erase <= 1'b0;
        o_burn_evt <= 1'b0;
        o_erase_evt <= 1'b0;
    end else begin
        o_fl_load <= 1'b0;
        o_burn_evt <= 1'b0;
        o_erase_evt <= 1'b0;
        if (apb_wr) begin
            case (i_paddr)
                `EFC_REG_CTRL: ctrl <= i_pwdata & 32'h0003_2070;
                `EFC_REG_WST: wait_state_count <= i_pwdata[7:0];
                `EFC_REG_LIDX: lidx <= i_pwdata[4:0];
                `EFC_REG_CMD: lidx <= 5'h00;
                12'h020: wbuf[31:0] <= i_pwdata;
                12'h024: wbuf[63:32] <= i_pwdata;
                12'h028: wbuf[95:64] <= i_pwdata;
                12'h02C: begin
                    // only whole words reach the latches
                    o_fl_load <= 1'b1;
                    o_fl_load_idx <= lidx;
                    o_fl_wdata <= {i_pwdata, wbuf};
                    // index wraps at 32 words per page
                    lidx <= lidx + 5'h01;
                end
                default: ;
            endcase
        end
        // Write-one-to-clear, a new event wins
        if (apb_wr & (i_paddr == `EFC_REG_STAT)) begin
            if (i_pwdata[`EFC_ST_BURN]) st_burn <= 1'b0;
            if (i_pwdata[`EFC_ST_ERASE]) st_erase <= 1'b0;
        end
        if (i_fl_op_done & (state == S_PROG)) begin
            if (op_erase) begin
                st_erase <= 1'b1;
                o_erase_evt <= 1'b1;
            end else begin
                st_burn <= 1'b1;
                o_burn_evt <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Program command intake from APB and JTAG
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        prog_pend <= 1'b0;
        prog_erase <= 1'b0;
        prog_page <= 10'h000;
        jtag_seen <= 1'b0;
        o_jtag_refused <= 1'b0;
        o_dbg_disable <= 1'b0;
        st_refused <= 1'b0;
    end else begin
        jtag_seen <= jreq;
        o_dbg_disable <= jprot;
        o_jtag_refused <= jreq & jprot;
        if (state == S_PROG)
            prog_pend <= 1'b0;
        // commands ignored while one is pending or running
        if (!prog_pend && state != S_PROG && init_done) begin
            if (apb_wr && i_paddr == `EFC_REG_CMD && (i_pwdata[`EFC_CMD_BURN] | i_pwdata[`EFC_CMD_ERASE])) begin
                prog_pend <= 1'b1;
                prog_erase <= i_pwdata[`EFC_CMD_ERASE];
                prog_page <= i_pwdata[`EFC_CMD_PAGE_LSB +: 10];
            end else if (jreq && !jtag_seen && !jprot) begin
                prog_pend <= 1'b1;
                prog_erase <= jtag_sync[10];
                prog_page <= jtag_sync[9:0];
            end
        end
        if (state == S_IDLE && prog_pend && !req_pend && !spec_busy && (!sec_hit || secure[prog_sector])) begin
            prog_pend <= 1'b0;
            st_refused <= 1'b1;
        end else if (apb_wr && i_paddr == `EFC_REG_STAT && i_pwdata[`EFC_ST_REFUSED]) begin
            st_refused <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read and program sequencer
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        state <= S_INIT;
        init_cnt <= 16'h0000;
        init_done <= 1'b0;
        jprot <= 1'b0;
        secure <= {SECTORS{1'b0}};
        req_pend <= 1'b0;
        req_addr <= 19'h0_0000;
        p_data <= 128'h0;
        s_data <= 128'h0;
        p_tag <= 15'h0000;
        s_tag <= 15'h0000;
        p_valid <= 1'b0;
        s_valid <= 1'b0;
        spec_busy <= 1'b0;
        spec_allow <= 1'b0;
        hold <= 128'h0;
        wcnt <= 8'h00;
        op_erase <= 1'b0;
        o_rd_data <= 32'h0000_0000;
        o_rd_ready <= 1'b0;
        o_fl_rd <= 1'b0;
        o_fl_addr <= 15'h0000;
        o_fl_index <= 1'b0;
        o_fl_latch <= 1'b0;
        o_fl_abort <= 1'b0;
        o_fl_burn <= 1'b0;
        o_fl_erase <= 1'b0;
        o_fl_page <= 10'h000;
    end else begin
        o_rd_ready <= 1'b0;
        o_fl_abort <= 1'b0;
        o_fl_burn <= 1'b0;
        o_fl_erase <= 1'b0;
        // Capture a read request when none is waiting; it waits until served
        if (i_rd_req && !req_pend) begin
            req_pend <= 1'b1;
            req_addr <= i_rd_addr;
        end
        case (state)
            S_INIT: begin
                // requests wait out the initialization time
                init_cnt <= init_cnt + 16'h0001;
                if (init_cnt == INIT_CYC[15:0]) begin
                    state <= S_IDXRD;
                    o_fl_rd <= 1'b1;
                    o_fl_index <= 1'b1;
                    o_fl_addr <= 15'h0000;
                end
            end
            S_IDXRD: begin
                // settings taken from the index sector
                if (i_fl_rvalid) begin
                    o_fl_rd <= 1'b0;
                    o_fl_index <= 1'b0;
                    jprot <= i_fl_rdata[`EFC_IDX_JPROT];
                    secure <= i_fl_rdata[`EFC_IDX_SEC_LSB +: SECTORS];
                    init_done <= 1'b1;
                    state <= S_IDLE;
                end
            end
            S_IDLE: begin
                if (spec_busy && i_fl_rvalid) begin
                    // Speculative word lands in the primary line
                    o_fl_rd <= 1'b0;
                    spec_busy <= 1'b0;
                    p_data <= i_fl_rdata;
                    p_tag <= o_fl_addr;
                    p_valid <= 1'b1;
                end else if (req_pend) begin
                    if (!bypass_md && p_hit) begin
                        o_rd_data <= pick(p_data, req_addr[3:2]);
                        o_rd_ready <= 1'b1;
                        req_pend <= 1'b0;
                        if (dual_md && !spec_busy && (ctrl[`EFC_CTRL_SPEC] || spec_allow)) begin
                            s_data <= p_data;
                            s_tag <= p_tag;
                            s_valid <= 1'b1;
                            spec_busy <= 1'b1;
                            spec_allow <= 1'b0;
                            o_fl_rd <= 1'b1;
                            o_fl_addr <= p_tag + 15'h0001;
                        end
                    end else if (!bypass_md && s_hit) begin
                        o_rd_data <= pick(s_data, req_addr[3:2]);
                        o_rd_ready <= 1'b1;
                        req_pend <= 1'b0;
                    end else if (spec_busy && !bypass_md && o_fl_addr == req_word) begin
                        // Wanted word already on its way
                        spec_busy <= 1'b1;
                    end else if (spec_busy) begin
                        o_fl_abort <= 1'b1;
                        o_fl_rd <= 1'b0;
                        spec_busy <= 1'b0;
                    end else begin
                        // miss: new flash read, wait states only in latch or index mode
                        o_fl_rd <= 1'b1;
                        o_fl_addr <= req_word;
                        o_fl_index <= index_md;
                        o_fl_latch <= latch_md;
                        // one speculative read after a miss
                        spec_allow <= dual_md;
                        state <= S_FLRD;
                    end
                end else if (prog_pend && !spec_busy && sec_hit && !secure[prog_sector]) begin
                    o_fl_page <= prog_page;
                    o_fl_burn <= ~prog_erase;
                    o_fl_erase <= prog_erase;
                    op_erase <= prog_erase;
                    state <= S_PROG;
                end
            end
            S_FLRD: begin
                if (i_fl_rvalid) begin
                    // flash returns to standby after the data
                    o_fl_rd <= 1'b0;
                    o_fl_index <= 1'b0;
                    o_fl_latch <= 1'b0;
                    if (latch_md || index_md) begin
                        hold <= i_fl_rdata;
                        wcnt <= wait_state_count;
                        state <= S_WST;
                    end else begin
                        o_rd_data <= pick(i_fl_rdata, req_addr[3:2]);
                        o_rd_ready <= 1'b1;
                        req_pend <= 1'b0;
                        state <= S_IDLE;
                        if (!bypass_md) begin
                            p_data <= i_fl_rdata;
                            p_tag <= req_word;
                            p_valid <= 1'b1;
                        end
                    end
                end
            end
            S_WST: begin
                wcnt <= wcnt - 8'h01;
                if (wcnt == 8'h00) begin
                    o_rd_data <= pick(hold, req_addr[3:2]);
                    o_rd_ready <= 1'b1;
                    req_pend <= 1'b0;
                    state <= S_IDLE;
                end
            end
            S_PROG: begin
                if (i_fl_op_done)
                    state <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
        if (state == S_IDXRD || cfg_acc || (state == S_FLRD && (latch_md || index_md))) begin
            p_valid <= 1'b0;
            s_valid <= 1'b0;
        end
    end
end

endmodule // efc_flash_ctrl

// ### test/efc_checker.sv
// Port checker for the embedded flash controller.
// Assumes it is bound onto efc_flash_ctrl with a short init count.
`timescale 1ns/1ps
module efc_checker (
    input wire i_core_clk, // Clock
    input wire i_rst_n, // Reset, active low
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire o_pready, // APB ready
    input wire o_rd_ready, // Read answer
    input wire o_fl_rd, // Flash read level
    input wire [14:0] o_fl_addr, // Flash word address
    input wire o_fl_abort, // Flash abort
    input wire i_fl_rvalid, // Flash data valid
    input wire o_fl_burn, // Burn start
    input wire o_fl_erase, // Erase start
    input wire i_fl_op_done, // Operation done
    input wire o_jtag_refused, // JTAG refused
    input wire o_dbg_disable, // Debug disabled
    input wire o_burn_evt, // Burn event
    input wire o_erase_evt // Erase event
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////
    property p_init; $rose(i_rst_n) |-> !o_rd_ready [*8]; endproperty
    a_init: assert property (p_init) else $error("answer during init");
    property p_hold; o_fl_rd && !i_fl_rvalid |=> (o_fl_rd && $stable(o_fl_addr)) || o_fl_abort; endproperty
    a_hold: assert property (p_hold) else $error("flash read dropped");
    property p_pulse; o_rd_ready |=> !o_rd_ready; endproperty
    a_pulse: assert property (p_pulse) else $error("answer too long");
    property p_apb; i_psel && !i_penable |=> o_pready; endproperty
    a_apb: assert property (p_apb) else $error("no ready");
    property p_bev; o_burn_evt |-> $past(i_fl_op_done); endproperty
    a_bev: assert property (p_bev) else $error("stray burn event");
    property p_eev; o_erase_evt |-> $past(i_fl_op_done); endproperty
    a_eev: assert property (p_eev) else $error("stray erase event");
    property p_run; o_fl_burn || o_fl_erase |=> !(o_fl_burn || o_fl_erase) [*3]; endproperty
    a_run: assert property (p_run) else $error("operation restarted");
    property p_jt; o_jtag_refused |-> o_dbg_disable; endproperty
    a_jt: assert property (p_jt) else $error("refused unprotected");
endmodule // efc_checker

bind efc_flash_ctrl efc_checker u_chk (.i_core_clk, .i_rst_n, .i_psel, .i_penable, .o_pready, .o_rd_ready,
    .o_fl_rd, .o_fl_addr, .o_fl_abort, .i_fl_rvalid, .o_fl_burn, .o_fl_erase, .i_fl_op_done,
    .o_jtag_refused, .o_dbg_disable, .o_burn_evt, .o_erase_evt);

// ### test/efc_flash_model.sv
// Behavioural flash array macro on the core clock.
// Assumes the controller holds its read request until data valid.
`timescale 1ns/1ps
module efc_flash_model (
    input wire i_core_clk, // Core clock
    input wire i_rd, // Read request level
    input wire [14:0] i_addr, // Word address
    input wire i_index, // Index sector read
    input wire i_burn, // Burn start
    input wire i_erase, // Erase start
    output reg o_rvalid = 1'b0, // Data valid pulse
    output reg [127:0] o_rdata = 128'h0, // Read word
    output reg o_done = 1'b0 // Operation done pulse
);
    // Index word: sector 2 secure, no protection
    localparam [127:0] IDX = {48'h0, 48'h4, 32'h5A5A_5A5A};
    reg [1:0] cnt = 2'h0; // Access delay
    reg [2:0] op = 3'h0; // Operation time left
    ////////////////////////////////////////
    // Fixed access time; data toggles when not valid
    always @(posedge i_core_clk) begin
        o_rvalid <= 1'b0;
        o_rdata <= ~o_rdata;
        cnt <= (i_rd && !o_rvalid) ? cnt + 2'h1 : 2'h0;
        if (i_rd && !o_rvalid && cnt == 2'h3) begin
            o_rvalid <= 1'b1;
            o_rdata <= i_index ? IDX : {8'hA3, 9'h0, i_addr, 8'hA2, 9'h0, i_addr, 8'hA1, 9'h0, i_addr, 8'hA0, 9'h0, i_addr};
        end
    end
    always @(posedge i_core_clk) begin
        o_done <= (op == 3'h1);
        op <= (i_burn || i_erase) ? 3'h4 : (op != 3'h0) ? op - 3'h1 : 3'h0;
    end
endmodule // efc_flash_model

// ### test/tb_embedded_flash_controller.sv
// Testbench: APB and read-port sequences against the flash model.
// Assumes a short init count passed to the controller.
`timescale 1ns/1ps
module tb_embedded_flash_controller;
    reg i_core_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_rd_req = 0;
    reg i_jtag_req = 0, i_jtag_erase = 0;
    reg [11:0] i_paddr = 12'h0;
    reg [31:0] i_pwdata = 32'h0, q;
    reg [18:0] i_rd_addr = 19'h0;
    reg [9:0] i_jtag_page = 10'h0, lp;
    reg [14:0] la;
    reg e;
    wire [31:0] o_prdata, o_rd_data;
    wire o_pready, o_pslverr, o_rd_ready, o_fl_rd, o_fl_index, o_fl_latch, o_fl_abort, i_fl_rvalid;
    wire i_fl_op_done, o_fl_load, o_fl_burn, o_fl_erase, o_jtag_refused, o_dbg_disable, o_burn_evt, o_erase_evt;
    wire [14:0] o_fl_addr;
    wire [127:0] i_fl_rdata, o_fl_wdata;
    wire [4:0] o_fl_load_idx;
    wire [9:0] o_fl_page;
    integer n_errors = 0, cmp_count = 0, n, b, i, nrv = 0, nld = 0, nbu = 0, ner = 0, nbe = 0, nee = 0, cyc = 0;
    efc_flash_ctrl #(.INIT_CYC(8)) dut (.i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rd_req, .i_rd_addr, .o_rd_data, .o_rd_ready, .o_fl_rd,
        .o_fl_addr, .o_fl_index, .o_fl_latch, .o_fl_abort, .i_fl_rvalid, .i_fl_rdata, .o_fl_load, .o_fl_load_idx,
        .o_fl_wdata, .o_fl_burn, .o_fl_erase, .o_fl_page, .i_fl_op_done, .i_jtag_req, .i_jtag_erase, .i_jtag_page,
        .o_jtag_refused, .o_dbg_disable, .o_burn_evt, .o_erase_evt);
    efc_flash_model fm (.i_core_clk, .i_rd(o_fl_rd), .i_addr(o_fl_addr), .i_index(o_fl_index), .i_burn(o_fl_burn),
        .i_erase(o_fl_erase), .o_rvalid(i_fl_rvalid), .o_rdata(i_fl_rdata), .o_done(i_fl_op_done));
    ////////////////////////////////////////
    // Clock, event counters and hang limit
    initial forever #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc = cyc + 1;
        nrv = nrv + i_fl_rvalid;
        nld = nld + o_fl_load;
        nbu = nbu + o_fl_burn;
        ner = ner + o_fl_erase;
        nbe = nbe + o_burn_evt;
        nee = nee + o_erase_evt;
        if (i_fl_rvalid) la = o_fl_addr;
        if (o_fl_erase) lp = o_fl_page;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end
    task give_verdict;
        begin
            $display("errors %0d compares %0d", n_errors, cmp_count);
            if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] x);
        begin
            cmp_count = cmp_count + 1;
            if (g !== x) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    // APB transfer; holds until ready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge i_core_clk);
            i_psel <= 1'b1;
            i_penable <= 1'b0;
            i_pwrite <= w;
            i_paddr <= a;
            i_pwdata <= d;
            @(posedge i_core_clk);
            i_penable <= 1'b1;
            @(posedge i_core_clk);
            while (o_pready !== 1'b1) @(posedge i_core_clk);
            q = o_prdata;
            e = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask
    // Read port request; n counts edges to the answer
    task rd(input [18:0] a);
        begin
            @(posedge i_core_clk);
            i_rd_req <= 1'b1;
            i_rd_addr <= a;
            @(posedge i_core_clk);
            i_rd_req <= 1'b0;
            n = 0;
            while (o_rd_ready !== 1'b1) begin
                @(posedge i_core_clk);
                n = n + 1;
            end
            q = o_rd_data;
        end
    endtask
    task settle;
        repeat (16) @(posedge i_core_clk);
    endtask
    function [31:0] xd(input [18:0] a);
        xd = {8'hA0 + {6'h0, a[3:2]}, 9'h0, a[18:4]};
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk(q[0], 0);
        rd(19'h100);
        chk(n > 8, 1);
        chk(q, xd(19'h100));
        apb(1'b0, 12'h004, 32'h0);
        chk(q[5:0], 6'h01);
        b = nrv;
        rd(19'h10C);
        chk(q, xd(19'h10C));
        chk(n, 2);
        rd(19'h110);
        chk(nrv - b, 1);
        apb(1'b1, 12'h010, 32'h4);
        rd(19'h114);
        chk(nrv - b, 2);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, 12'h000, (i == 0) ? 32'h2000 : (i == 1) ? 32'h2010 : (i == 2) ? 32'h10 : 32'h20);
            b = nrv;
            rd(19'h130);
            rd(19'h138);
            chk(q, xd(19'h138));
            chk(nrv - b, (i == 2) ? 1 : 2);
        end
        apb(1'b1, 12'h000, 32'h30010);
        rd(19'h200);
        rd(19'h204);
        chk(q, xd(19'h204));
        settle;
        chk(la, 15'h21);
        rd(19'h214);
        chk(q, xd(19'h214));
        apb(1'b1, 12'h000, 32'h40);
        settle;
        b = nrv;
        rd(19'h0);
        chk(q, 32'h5A5A_5A5A);
        rd(19'h0);
        chk(nrv - b, 2);
        apb(1'b1, 12'h000, 32'h0);
        for (i = 0; i < 3; i = i + 1) apb(1'b1, 12'h020 + i[11:0] * 12'h4, i);
        settle;
        chk(nld, 0);
        apb(1'b1, 12'h02C, 32'h3);
        settle;
        chk(nld, 1);
        apb(1'b1, 12'h008, 32'h0001_0001);
        settle;
        chk(nbe, 1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q[5:0], 6'h05);
        apb(1'b1, 12'h004, 32'h4);
        apb(1'b1, 12'h008, 32'h0020_0002);
        apb(1'b1, 12'h008, 32'h0300_0002);
        settle;
        chk(ner, 0);
        apb(1'b0, 12'h004, 32'h0);
        chk(q[5:0], 6'h11);
        apb(1'b1, 12'h008, 32'h0010_0002);
        settle;
        chk(nee, 1);
        chk(lp, 10'd16);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(e, 1);
        chk(q, 32'h0);
        i_jtag_page <= 10'd5;
        i_jtag_req <= 1'b1;
        settle;
        chk(nbu, 2);
        chk({o_jtag_refused, o_dbg_disable}, 2'b00);
        give_verdict;
    end
endmodule // tb_embedded_flash_controller
